// *** include/i2hs_defines.vh ***
// Constants for the I2C host sequencer: register offsets, field positions, resets, timing.
// Assumes a plain register port with one-word registers addressed by index.
`ifndef I2HS_DEFINES_VH
`define I2HS_DEFINES_VH

`define I2HS_ADDR_W 3
`define I2HS_REG_CTRL 3'h0
`define I2HS_REG_STAT 3'h1
`define I2HS_REG_BUF 3'h2
`define I2HS_REG_BAUD 3'h3

`define I2HS_CTRL_RESTART 0
`define I2HS_CTRL_STOP 1
`define I2HS_CTRL_ACKSEQ 2
`define I2HS_CTRL_ACKVAL 3

`define I2HS_ST_BF 0
`define I2HS_ST_WRITE_COLLISION_FLAG 1
`define I2HS_ST_RECEIVED_ACK_STATUS 2
`define I2HS_ST_IF 3
`define I2HS_ST_BCOL 4
`define I2HS_ST_START 5
`define I2HS_ST_STOP 6
`define I2HS_ST_BUSY 7

`define I2HS_BAUD_RESET 8'h04

`endif

// *** core/i2hs_sequencer.v ***
// I2C host sequencer: repeated start, acknowledge, stop and byte transmission.
// Assumes synchronous pad inputs and open-drain pads driven low when oe_n is low.
`timescale 1ns/10ps
`include "i2hs_defines.vh"

module i2hs_sequencer #(
  parameter BAUD_W = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [`I2HS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_RS_LOW = 4'h1;
  localparam [3:0] ST_RS_SDAHI = 4'h2;
  localparam [3:0] ST_RS_SCLHI = 4'h3;
  localparam [3:0] ST_RS_SDALO = 4'h4;
  localparam [3:0] ST_ACK_LO = 4'h5;
  localparam [3:0] ST_ACK_HI = 4'h6;
  localparam [3:0] ST_P_SDALO = 4'h7;
  localparam [3:0] ST_P_SCLHI = 4'h8;
  localparam [3:0] ST_P_SDAHI = 4'h9;
  localparam [3:0] ST_P_END = 4'ha;
  localparam [3:0] ST_TX_LO = 4'hb;
  localparam [3:0] ST_TX_HI = 4'hc;
  localparam [3:0] ST_RS_WAIT = 4'hd;

  reg [3:0] state;
  reg [BAUD_W-1:0] baud_reload_value;
  reg [BAUD_W-1:0] brg;
  reg [7:0] shift_buffer;
  reg [7:0] shift_register;
  reg [3:0] bit_cnt;
  reg restart_request;
  reg stop_request;
  reg ack_sequence_request;
  reg ack_value_to_send;
  reg received_ack_status;
  reg buffer_full_flag;
  reg write_collision_flag;
  reg port_interrupt_flag;
  reg bus_collision_flag;
  reg start_seen;
  reg stop_seen;
  reg scl_drive_low;
  reg sda_drive_low;
  reg scl_q;
  reg sda_q;

  wire brg_zero = (brg == {BAUD_W{1'b0}});
  wire idle = (state == ST_IDLE);
  wire wr_ctrl = reg_wr && (reg_addr == `I2HS_REG_CTRL);
  wire wr_stat = reg_wr && (reg_addr == `I2HS_REG_STAT);
  wire wr_buf = reg_wr && (reg_addr == `I2HS_REG_BUF);
  wire wr_baud = reg_wr && (reg_addr == `I2HS_REG_BAUD);
  // Buffer write is accepted only when the engine is idle and no condition is pending.
  wire buf_ok = idle && !restart_request && !stop_request && !ack_sequence_request;

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_drive_low;
  assign sda_oe_n = ~sda_drive_low;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `I2HS_REG_CTRL) begin
        reg_rdata <= {4'h0, ack_value_to_send, ack_sequence_request, stop_request,
                      restart_request};
      end else if (reg_addr == `I2HS_REG_STAT) begin
        reg_rdata <= {~idle, stop_seen, start_seen, bus_collision_flag, port_interrupt_flag,
                      received_ack_status, write_collision_flag, buffer_full_flag};
      end else if (reg_addr == `I2HS_REG_BUF) begin
        reg_rdata <= shift_buffer;
      end else if (reg_addr == `I2HS_REG_BAUD) begin
        reg_rdata <= baud_reload_value;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Bus pattern detection runs whatever the engine is doing.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      baud_reload_value <= `I2HS_BAUD_RESET;
      brg <= {BAUD_W{1'b0}};
      shift_buffer <= 8'h00;
      shift_register <= 8'h00;
      bit_cnt <= 4'h0;
      restart_request <= 1'b0;
      stop_request <= 1'b0;
      ack_sequence_request <= 1'b0;
      ack_value_to_send <= 1'b0;
      received_ack_status <= 1'b0;
      buffer_full_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      port_interrupt_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      scl_drive_low <= 1'b0;
      sda_drive_low <= 1'b0;
    end else begin
      if (wr_baud) begin
        baud_reload_value <= reg_wdata[BAUD_W-1:0];
      end
      // Software clears the collision, interrupt, start and stop flags by writing one; a hardware set below wins.
      if (wr_stat) begin
        if (reg_wdata[`I2HS_ST_WRITE_COLLISION_FLAG]) write_collision_flag <= 1'b0;
        if (reg_wdata[`I2HS_ST_IF]) port_interrupt_flag <= 1'b0;
        if (reg_wdata[`I2HS_ST_BCOL]) bus_collision_flag <= 1'b0;
        if (reg_wdata[`I2HS_ST_START]) start_seen <= 1'b0;
        if (reg_wdata[`I2HS_ST_STOP]) stop_seen <= 1'b0;
      end
      if (wr_ctrl) begin
        ack_value_to_send <= reg_wdata[`I2HS_CTRL_ACKVAL];
        if (buf_ok) begin
          restart_request <= reg_wdata[`I2HS_CTRL_RESTART];
          stop_request <= reg_wdata[`I2HS_CTRL_STOP];
          ack_sequence_request <= reg_wdata[`I2HS_CTRL_ACKSEQ];
        end
      end
      if (scl_q && scl_in && sda_q && !sda_in) start_seen <= 1'b1;
      if (scl_q && scl_in && !sda_q && sda_in) stop_seen <= 1'b1;
      if (wr_buf && !buf_ok) begin
        write_collision_flag <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (wr_buf && buf_ok) begin
            shift_buffer <= reg_wdata;
            shift_register <= reg_wdata;
            buffer_full_flag <= 1'b1;
            bit_cnt <= 4'h0;
            scl_drive_low <= 1'b1;
            sda_drive_low <= ~reg_wdata[7];
            brg <= baud_reload_value;
            state <= ST_TX_LO;
          end else if (restart_request) begin
            scl_drive_low <= 1'b1;
            state <= ST_RS_LOW;
          end else if (ack_sequence_request) begin
            scl_drive_low <= 1'b1;
            sda_drive_low <= ~ack_value_to_send;
            brg <= baud_reload_value;
            state <= ST_ACK_LO;
          end else if (stop_request) begin
            scl_drive_low <= 1'b1;
            sda_drive_low <= 1'b1;
            state <= ST_P_SDALO;
          end
        end
        ST_RS_LOW: begin
          if (!scl_in) begin
            brg <= baud_reload_value;
            sda_drive_low <= 1'b0;
            state <= ST_RS_SDAHI;
          end
        end
        ST_RS_SDAHI: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else if (sda_in) begin
            scl_drive_low <= 1'b0;
            state <= ST_RS_WAIT;
          end
        end
        ST_RS_WAIT: begin
          if (scl_in) begin
            if (!sda_in) begin
              bus_collision_flag <= 1'b1;
              restart_request <= 1'b0;
              state <= ST_IDLE;
            end else begin
              brg <= baud_reload_value;
              state <= ST_RS_SCLHI;
            end
          end
        end
        ST_RS_SCLHI: begin
          if (!scl_in) begin
            bus_collision_flag <= 1'b1;
            restart_request <= 1'b0;
            state <= ST_IDLE;
          end else if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else begin
            sda_drive_low <= 1'b1;
            brg <= baud_reload_value;
            state <= ST_RS_SDALO;
          end
        end
        ST_RS_SDALO: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else begin
            scl_drive_low <= 1'b1;
            restart_request <= 1'b0;
            port_interrupt_flag <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_ACK_LO: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else if (scl_drive_low) begin
            scl_drive_low <= 1'b0;
          end else if (scl_in) begin
            brg <= baud_reload_value;
            state <= ST_ACK_HI;
          end
        end
        ST_ACK_HI: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else begin
            scl_drive_low <= 1'b1;
            ack_sequence_request <= 1'b0;
            port_interrupt_flag <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_P_SDALO: begin
          if (!sda_in) begin
            brg <= baud_reload_value;
            state <= ST_P_SCLHI;
          end
        end
        ST_P_SCLHI: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else if (scl_drive_low) begin
            scl_drive_low <= 1'b0;
          end else if (scl_in) begin
            brg <= baud_reload_value;
            state <= ST_P_SDAHI;
          end
        end
        ST_P_SDAHI: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else begin
            sda_drive_low <= 1'b0;
            if (sda_in && scl_in) begin
              brg <= baud_reload_value;
              state <= ST_P_END;
            end
          end
        end
        ST_P_END: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else begin
            stop_request <= 1'b0;
            port_interrupt_flag <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_TX_LO: begin
          if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else if (scl_drive_low) begin
            scl_drive_low <= 1'b0;
          end else if (scl_in) begin
            brg <= baud_reload_value;
            state <= ST_TX_HI;
          end
        end
        ST_TX_HI: begin
          // Arbitration loss on a released one.
          if (!sda_drive_low && !sda_in && bit_cnt != 4'h8) begin
            bus_collision_flag <= 1'b1;
            buffer_full_flag <= 1'b0;
            sda_drive_low <= 1'b0;
            state <= ST_IDLE;
          end else if (!brg_zero) begin
            brg <= brg - 1'b1;
          end else begin
            scl_drive_low <= 1'b1;
            brg <= baud_reload_value;
            if (bit_cnt == 4'h8) begin
              received_ack_status <= sda_in;
              port_interrupt_flag <= 1'b1;
              state <= ST_IDLE;
            end else if (bit_cnt == 4'h7) begin
              buffer_full_flag <= 1'b0;
              sda_drive_low <= 1'b0;
              bit_cnt <= bit_cnt + 4'h1;
              state <= ST_TX_LO;
            end else begin
              shift_register <= {shift_register[6:0], 1'b0};
              sda_drive_low <= ~shift_register[6];
              bit_cnt <= bit_cnt + 4'h1;
              state <= ST_TX_LO;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // i2hs_sequencer

// *** testbench/i2hs_sequencer_checker.sv ***
// Checker for the I2C host sequencer: register port and line timing.
// Assumes only the top ports; the baud and acknowledge values are tracked from bus writes.
`timescale 1ns/10ps
`include "i2hs_defines.vh"
module i2hs_sequencer_checker #(
  parameter BAUD_W = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [`I2HS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe_n,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n
);
  reg [BAUD_W-1:0] baud_sh;
  reg ack_sh;
  reg [7:0] lo_cnt;
  reg [7:0] hi_cnt;
  // Counters saturate so that a long hold never wraps back below the minimum.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_sh <= `I2HS_BAUD_RESET;
      ack_sh <= 1'b0;
      lo_cnt <= 8'h00;
      hi_cnt <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `I2HS_REG_BAUD)
        baud_sh <= reg_wdata[BAUD_W-1:0];
      if (reg_wr && reg_addr == `I2HS_REG_CTRL)
        ack_sh <= reg_wdata[`I2HS_CTRL_ACKVAL];
      lo_cnt <= scl_oe_n ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
      hi_cnt <= !scl_in ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence scl_let_go;
    $rose(scl_oe_n);
  endsequence
  sequence scl_pulled;
    $fell(scl_oe_n);
  endsequence
  sequence ack_req;
    reg_wr && reg_addr == `I2HS_REG_CTRL && reg_wdata[`I2HS_CTRL_ACKSEQ] && !scl_oe_n && sda_oe_n;
  endsequence
  pins_od_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin output level not low");
  reset_free_a: assert property (disable iff (1'b0) !rst_n |-> scl_oe_n && sda_oe_n)
    else $error("lines pulled during reset");
  rd_quiet_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  rd_unmapped_a: assert property (reg_rd && reg_addr > `I2HS_REG_BAUD |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  baud_read_a: assert property (reg_rd && reg_addr == `I2HS_REG_BAUD |=> reg_rdata[BAUD_W-1:0] == baud_sh)
    else $error("baud readback wrong");
  scl_low_time_a: assert property (scl_let_go |-> lo_cnt >= baud_sh)
    else $error("clock low time short");
  scl_high_time_a: assert property (scl_pulled |-> hi_cnt >= baud_sh)
    else $error("clock high time short");
  ack_drive_a: assert property (ack_req |-> ##[1:4] (!scl_oe_n && sda_oe_n == ack_sh))
    else $error("acknowledge value not driven");
endmodule // i2hs_sequencer_checker
bind i2hs_sequencer i2hs_sequencer_checker #(.BAUD_W(BAUD_W)) u_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// *** testbench/i2hs_client_model.sv ***
// I2C client model: shifts in bytes, answers ACK or NACK, may stretch SCL.
// Assumes wired-AND line levels sampled on the system clock.
`timescale 1ns/10ps
module i2hs_client_model #(
  parameter STRETCH = 12
) (
  input wire sys_clk,
  input wire rst_n,
  input wire scl,
  input wire sda,
  input wire ack_en,
  input wire stretch_en,
  output wire scl_hold_n,
  output reg sda_hold_n,
  output reg [7:0] rx_byte
);
  reg scl_d;
  reg sda_d;
  reg [3:0] bit_cnt;
  reg [7:0] st_cnt;
  assign scl_hold_n = (st_cnt == 8'h00);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bit_cnt <= 4'h0;
      st_cnt <= 8'h00;
      sda_hold_n <= 1'b1;
      rx_byte <= 8'h00;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (st_cnt != 8'h00)
        st_cnt <= st_cnt - 8'h01;
      if (scl && scl_d && sda_d && !sda) begin
        bit_cnt <= 4'h0;
      end else if (scl && !scl_d) begin
        if (bit_cnt < 4'h8)
          rx_byte <= {rx_byte[6:0], sda};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (!scl && scl_d) begin
        if (stretch_en)
          st_cnt <= STRETCH[7:0];
        if (bit_cnt == 4'h8)
          sda_hold_n <= !ack_en;
        if (bit_cnt == 4'h9) begin
          sda_hold_n <= 1'b1;
          bit_cnt <= 4'h0;
        end
      end
    end
  end
endmodule // i2hs_client_model

// *** testbench/i2hs_sequencer_tb_top.sv ***
// Testbench for the I2C host sequencer with one client model on the bus.
// Assumes pull-ups on both lines; the bench drives the register port.
`timescale 1ns/10ps
`include "i2hs_defines.vh"
module i2hs_sequencer_tb_top;
  reg sys_clk;
  reg rst_n;
  reg [`I2HS_ADDR_W-1:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg ack_en;
  reg stretch_en;
  reg [7:0] got;
  integer error_cnt;
  integer num_checks;
  wire [7:0] reg_rdata;
  wire [7:0] rx_byte;
  wire scl_oe_n;
  wire sda_oe_n;
  wire scl_hold_n;
  wire sda_hold_n;
  // Any party pulling a line low wins over the pull-up.
  wire scl = scl_oe_n & scl_hold_n;
  wire sda = sda_oe_n & sda_hold_n;
  i2hs_sequencer #(.BAUD_W(8)) i_i2hs_sequencer (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(), .sda_oe_n(sda_oe_n));
  i2hs_client_model #(.STRETCH(12)) i_i2hs_client_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .scl(scl), .sda(sda), .ack_en(ack_en), .stretch_en(stretch_en),
    .scl_hold_n(scl_hold_n), .sda_hold_n(sda_hold_n), .rx_byte(rx_byte));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input [8*8-1:0] name, input [7:0] exp, input [7:0] seen);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input [`I2HS_ADDR_W-1:0] a, input [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [`I2HS_ADDR_W-1:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task final_report;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Polls status until busy drops; the last status stays in got.
  task wait_idle;
    integer n;
    n = 0;
    got = 8'hff;
    while (got[`I2HS_ST_BUSY] !== 1'b0 && n < 300) begin
      rd(`I2HS_REG_STAT);
      n = n + 1;
    end
    if (got[`I2HS_ST_BUSY] !== 1'b0) begin
      error_cnt = error_cnt + 1;
      $display("BAD wait_idle expected 0 seen 1");
      final_report;
    end
  endtask
  initial begin
    rst_n = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack_en = 1'b1;
    stretch_en = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    // Reset falls after time zero so that every reset process sees the edge.
    #1 rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`I2HS_REG_STAT);
    chk("status", 8'h00, got);
    rd(`I2HS_REG_BAUD);
    chk("baud", `I2HS_BAUD_RESET, got);
    rd(3'h5);
    chk("unmapped", 8'h00, got);
    wr(`I2HS_REG_BAUD, 8'h03);
    rd(`I2HS_REG_BAUD);
    chk("baud", 8'h03, got);
    wr(`I2HS_REG_CTRL, 8'h01);
    wait_idle;
    chk("status", 8'h28, got);
    rd(`I2HS_REG_CTRL);
    chk("ctrl", 8'h00, got);
    chk("sda", 8'h00, {7'h00, sda});
    wr(`I2HS_REG_STAT, 8'h7a);
    wr(`I2HS_REG_BUF, 8'ha0);
    rd(`I2HS_REG_STAT);
    chk("status", 8'h81, got);
    wr(`I2HS_REG_BUF, 8'h55);
    wait_idle;
    chk("status", 8'h0a, got);
    chk("rx", 8'ha0, rx_byte);
    chk("scl", 8'h00, {7'h00, scl});
    chk("sda", 8'h01, {7'h00, sda});
    wr(`I2HS_REG_STAT, 8'h7a);
    ack_en <= 1'b0;
    stretch_en <= 1'b1;
    wr(`I2HS_REG_BUF, 8'h5a);
    wr(`I2HS_REG_CTRL, 8'h01);
    wait_idle;
    chk("status", 8'h0c, got);
    chk("rx", 8'h5a, rx_byte);
    wr(`I2HS_REG_STAT, 8'h7a);
    wr(`I2HS_REG_CTRL, 8'h0c);
    wait_idle;
    rd(`I2HS_REG_CTRL);
    chk("ctrl", 8'h08, got);
    wr(`I2HS_REG_CTRL, 8'h04);
    wait_idle;
    chk("sda", 8'h00, {7'h00, sda});
    chk("status", 8'h0c, got);
    wr(`I2HS_REG_STAT, 8'h7a);
    wr(`I2HS_REG_CTRL, 8'h0a);
    wr(`I2HS_REG_BUF, 8'h33);
    wait_idle;
    chk("status", 8'h4e, got);
    chk("lines", 8'h03, {6'h00, scl, sda});
    wr(`I2HS_REG_BUF, 8'hc3);
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    chk("lines", 8'h03, {6'h00, scl, sda});
    rst_n <= 1'b1;
    rd(`I2HS_REG_STAT);
    chk("status", 8'h00, got);
    rd(`I2HS_REG_BAUD);
    chk("baud", `I2HS_BAUD_RESET, got);
    final_report;
  end
endmodule // i2hs_sequencer_tb_top
